// ### pkg/otc_map.svh
// Register offsets, field positions, reset values and timing counts of the oscillator trim block.
// Assumes inclusion by bare name from design files.
`ifndef OTC_MAP_SVH
`define OTC_MAP_SVH

`define OTC_OFF_IDENT      8'h08
`define OTC_OFF_CALRES     8'h0A
`define OTC_OFF_SRST       8'h0F
`define OTC_OFF_SLOW       8'h18
`define OTC_OFF_FAST       8'h1A
`define OTC_OFF_CALCTL     8'h30
`define OTC_OFF_CLKCTL     8'h32
`define OTC_OFF_RATE       8'h40
`define OTC_OFF_SLEW       8'h41
`define OTC_OFF_FRATE      8'h44
`define OTC_OFF_MODE       8'h45
`define OTC_OFF_FSTAT      8'h49
`define OTC_OFF_FDATA      8'h60

`define OTC_BIT_SRST       0
`define OTC_BIT_SLOW_EN    7
`define OTC_BIT_FAST_EN_A  3
`define OTC_BIT_FAST_EN_B  11
`define OTC_BIT_CAL_GO     5
`define OTC_BIT_FLUSH      15
`define OTC_MODE_SAMPLE    4'h8
`define OTC_MODE_IDLE      4'h0
`define OTC_RATE_50HZ      4'h8
`define OTC_DIV_50HZ       16'h0280
`define OTC_SLOW_TRIM_RST  6'h20
`define OTC_FAST_TRIM_RST  8'h80
`define OTC_CLKCTL_RST     16'h0040
`define OTC_CAL_SLOW_PER   2
`define OTC_CAL_MAX        12'hFFF
`define OTC_SLOW_HZ        32000
`define OTC_FAST_HZ        32000000
`define OTC_CLK_HZ         200000000

`endif

// ### pkg/otc_pkg.sv
// Types of the oscillator trim block.
// Assumes otc_map.svh supplies the numeric constants.
package otc_pkg;
  typedef enum logic [2:0] {
    OTC_CAL_IDLE = 3'b001,
    OTC_CAL_ARM  = 3'b010,
    OTC_CAL_RUN  = 3'b100
  } otc_cal_state_t;
endpackage : otc_pkg

// ### hw/otc_osc.sv
// Trimmable oscillator model: a phase accumulator on the system clock.
// Assumes trim and enable come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module otc_osc #(
  parameter int TRIM_W = 6,
  parameter int ACC_W  = 32,
  parameter logic [31:0] BASE_INC = 32'h0000_0001,
  parameter logic [31:0] STEP_INC = 32'h0000_0001
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // Control
  input  wire logic              enable_i,
  input  wire logic [TRIM_W-1:0] trim_i,
  // Output tick, one cycle per oscillator period
  output logic                   tick_o
);
  if (TRIM_W < 1 || TRIM_W > 16 || ACC_W != 32)
  begin : g_bad_param
    $error("otc_osc: bad parameters");
  end

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic             tick;
  } otc_osc_state_t;

  otc_osc_state_t st;
  otc_osc_state_t next_st;
  logic [ACC_W:0] sum;

  always_comb
  begin
    next_st = st;
    // Larger trim gives a larger step, so a higher frequency; takes effect at once
    sum = {1'b0, st.acc} + {1'b0, BASE_INC} + 33'(STEP_INC * 32'(trim_i));
    if (enable_i)
    begin
      next_st.acc  = sum[ACC_W-1:0];
      next_st.tick = sum[ACC_W];
    end
    else
    begin
      next_st.tick = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick_o = st.tick;
endmodule : otc_osc
`default_nettype wire

// ### hw/otc_ratediv.sv
// Output rate divider: counts slow ticks and pulses once per sample period.
// Assumes ticks come from the slow oscillator on the same clock.
`timescale 1ns/1ps
`default_nettype none
module otc_ratediv #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  // Control
  input  wire logic             run_i,
  input  wire logic             tick_i,
  input  wire logic [CNT_W-1:0] div_i,
  // Sample strobe
  output logic                  sample_o
);
  if (CNT_W < 2)
  begin : g_bad_width
    $error("otc_ratediv: bad width");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             smp;
  } otc_div_state_t;

  otc_div_state_t st;
  otc_div_state_t next_st;

  always_comb
  begin
    next_st     = st;
    next_st.smp = 1'b0;
    if (!run_i)
      next_st.cnt = '0;
    else if (tick_i)
    begin
      // Sample period derived from slow clock ticks
      if (st.cnt + 1'b1 >= div_i)
      begin
        next_st.cnt = '0;
        next_st.smp = 1'b1;
      end
      else
        next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign sample_o = st.smp;
endmodule : otc_ratediv
`default_nettype wire

// ### hw/otc_core.sv
// Oscillator trim and calibration core with its register file.
// Assumes a register port decoded upstream from the serial link, one access per strobe.
`timescale 1ns/1ps
`default_nettype none
`include "otc_map.svh"
module otc_core #(
  parameter logic [11:0] PART_ID  = 12'h5A5, // Arbitrary value
  parameter logic [3:0]  VERSION  = 4'h1,    // Arbitrary value
  parameter int          FIFO_DEPTH = 32
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic [15:0]      reg_rdata_o,
  output logic             reg_ack_o,
  // Sample source
  input  wire logic [15:0] sample_data_i,
  // Timing outputs
  output logic             sample_o,
  output logic             fast_tick_o,
  output logic             fast_run_o
);
  // Pointers wrap naturally and the byte count fits seven bits
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 32 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("otc_core: bad FIFO depth");
  end

  localparam int PW = $clog2(FIFO_DEPTH);

  typedef struct packed {
    logic [5:0]            slow_trim;
    logic                  slow_en;
    logic [7:0]            fast_trim;
    logic [15:0]           cal_ctl;
    logic [15:0]           clk_ctl;
    logic [3:0]            rate;
    logic [15:0]           slew;
    logic [15:0]           frate;
    logic [15:0]           mode;
    logic [11:0]           cal_res;
    logic [11:0]           cal_cnt;
    logic [1:0]            cal_per;
    otc_pkg::otc_cal_state_t cal_st;
    logic [FIFO_DEPTH-1:0][15:0] mem;
    logic [PW-1:0]         wp;
    logic [PW-1:0]         rp;
    logic [PW:0]           level;
    logic [15:0]           rdata;
    logic                  ack;
  } otc_core_state_t;

  otc_core_state_t st;
  otc_core_state_t next_st;
  logic            slow_tick;
  logic            fast_tick;
  logic            smp;
  logic            sampling;
  logic            fast_en;
  logic            srst;
  logic [15:0]     div;
  logic [31:0]     div_full;
  logic            push;
  logic            pop;

  assign sampling = st.mode[3:0] == `OTC_MODE_SAMPLE;
  assign fast_en  = st.clk_ctl[`OTC_BIT_FAST_EN_A] & st.clk_ctl[`OTC_BIT_FAST_EN_B];
  assign srst     = reg_wr_i && reg_addr_i == `OTC_OFF_SRST && reg_wdata_i[`OTC_BIT_SRST];

  // Slow ticks per sample: fast rate low byte wins when nonzero, else rate code; code 8 = 640 ticks = 50 Hz
  // Higher rate code runs faster; codes 0 and 1 saturate the divider
  always_comb
  begin
    div_full = (32'(`OTC_DIV_50HZ) << 8) >> st.rate;
    if (st.frate[7:0] != 8'h00)
      div = 16'(32'(st.frate[7:0]) + 32'h0000_000C);
    else if (div_full > 32'h0000_FFFF)
      div = 16'hFFFF;
    else
      div = div_full[15:0];
  end

  otc_osc #(
    .TRIM_W   (6),
    .ACC_W    (32),
    .BASE_INC (32'h000A_3D70),
    .STEP_INC (32'h0000_5000)
  ) u_slow (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .enable_i (st.slow_en),
    .trim_i   (st.slow_trim),
    .tick_o   (slow_tick)
  );

  otc_osc #(
    .TRIM_W   (8),
    .ACC_W    (32),
    .BASE_INC (32'h1999_9999),
    .STEP_INC (32'h0010_0000)
  ) u_fast (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .enable_i (fast_en | sampling),
    .trim_i   (st.fast_trim),
    .tick_o   (fast_tick)
  );

  otc_ratediv #(
    .CNT_W (16)
  ) u_div (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .run_i    (sampling & st.slow_en),
    .tick_i   (slow_tick),
    .div_i    (div),
    .sample_o (smp)
  );

  assign push = smp && st.level != (PW+1)'(FIFO_DEPTH);
  assign pop  = reg_rd_i && reg_addr_i == `OTC_OFF_FDATA && st.level != '0;

  always_comb
  begin
    next_st     = st;
    next_st.ack = 1'b0;
    // Calibration window of two slow periods
    case (st.cal_st)
      otc_pkg::OTC_CAL_IDLE:
      begin
        if (st.cal_ctl[`OTC_BIT_CAL_GO])
          next_st.cal_st = otc_pkg::OTC_CAL_ARM;
      end
      otc_pkg::OTC_CAL_ARM:
      begin
        if (slow_tick)
        begin
          next_st.cal_cnt = '0;
          next_st.cal_per = '0;
          next_st.cal_st  = otc_pkg::OTC_CAL_RUN;
        end
      end
      otc_pkg::OTC_CAL_RUN:
      begin
        if (fast_tick && st.cal_cnt != `OTC_CAL_MAX)
          next_st.cal_cnt = st.cal_cnt + 12'h001;
        if (slow_tick)
        begin
          next_st.cal_per = st.cal_per + 2'h1;
          if (st.cal_per + 2'h1 == 2'(`OTC_CAL_SLOW_PER))
          begin
            next_st.cal_res = st.cal_cnt;
            next_st.cal_st  = otc_pkg::OTC_CAL_IDLE;
          end
        end
      end
      default: next_st.cal_st = otc_pkg::OTC_CAL_IDLE;
    endcase
    if (!st.cal_ctl[`OTC_BIT_CAL_GO])
      next_st.cal_st = otc_pkg::OTC_CAL_IDLE;

    if (push)
    begin
      next_st.mem[st.wp] = sample_data_i;
      next_st.wp         = st.wp + 1'b1;
    end
    if (pop)
      next_st.rp = st.rp + 1'b1;
    next_st.level = st.level + (PW+1)'(push) - (PW+1)'(pop);

    if (reg_rd_i)
    begin
      next_st.ack = 1'b1;
      case (reg_addr_i)
        `OTC_OFF_IDENT:  next_st.rdata = {VERSION, PART_ID};
        `OTC_OFF_CALRES: next_st.rdata = {4'h0, st.cal_res};
        `OTC_OFF_SLOW:   next_st.rdata = {8'h00, st.slow_en, 1'b0, st.slow_trim};
        `OTC_OFF_FAST:   next_st.rdata = {8'h00, st.fast_trim};
        `OTC_OFF_CALCTL: next_st.rdata = st.cal_ctl;
        `OTC_OFF_CLKCTL: next_st.rdata = st.clk_ctl;
        `OTC_OFF_RATE:   next_st.rdata = {12'h000, st.rate};
        `OTC_OFF_SLEW:   next_st.rdata = st.slew;
        `OTC_OFF_FRATE:  next_st.rdata = st.frate;
        `OTC_OFF_MODE:   next_st.rdata = st.mode;
        `OTC_OFF_FSTAT:  next_st.rdata = {1'b0, 7'(st.level * 2), 8'h00};
        `OTC_OFF_FDATA:  next_st.rdata = st.level != '0 ? st.mem[st.rp] : 16'h0000;
        default:         next_st.rdata = 16'h0000;
      endcase
    end

    if (reg_wr_i)
    begin
      next_st.ack = 1'b1;
      case (reg_addr_i)
        `OTC_OFF_SLOW:
        begin
          next_st.slow_trim = reg_wdata_i[5:0];
          next_st.slow_en   = reg_wdata_i[`OTC_BIT_SLOW_EN];
        end
        `OTC_OFF_FAST:   next_st.fast_trim = reg_wdata_i[7:0];
        `OTC_OFF_CALCTL:
        begin
          next_st.cal_ctl = reg_wdata_i;
          if (reg_wdata_i[`OTC_BIT_CAL_GO])
            next_st.cal_st = otc_pkg::OTC_CAL_ARM;
        end
        `OTC_OFF_CLKCTL: next_st.clk_ctl = reg_wdata_i;
        `OTC_OFF_RATE:   next_st.rate    = reg_wdata_i[3:0];
        `OTC_OFF_SLEW:   next_st.slew    = reg_wdata_i;
        `OTC_OFF_FRATE:  next_st.frate   = reg_wdata_i;
        `OTC_OFF_MODE:   next_st.mode    = reg_wdata_i;
        `OTC_OFF_FSTAT:
        begin
          if (reg_wdata_i[`OTC_BIT_FLUSH])
          begin
            next_st.wp    = '0;
            next_st.rp    = '0;
            next_st.level = '0;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st           <= '0;
      st.slow_trim <= `OTC_SLOW_TRIM_RST;
      st.fast_trim <= `OTC_FAST_TRIM_RST;
      st.clk_ctl   <= `OTC_CLKCTL_RST;
      st.rate      <= `OTC_RATE_50HZ;
      st.cal_st    <= otc_pkg::OTC_CAL_IDLE;
    end
    else if (srst)
    begin
      // Immediate return to defaults, no acknowledge
      st           <= '0;
      st.slow_trim <= `OTC_SLOW_TRIM_RST;
      st.fast_trim <= `OTC_FAST_TRIM_RST;
      st.clk_ctl   <= `OTC_CLKCTL_RST;
      st.rate      <= `OTC_RATE_50HZ;
      st.cal_st    <= otc_pkg::OTC_CAL_IDLE;
    end
    else
      st <= next_st;
  end

  assign reg_rdata_o = st.rdata;
  assign reg_ack_o   = st.ack;
  assign sample_o    = smp;
  assign fast_tick_o = fast_tick;
  assign fast_run_o  = fast_en | sampling;

  a_srst_no_ack: assert property (@(posedge clk_i) disable iff (!resetn_i)
    srst |=> !reg_ack_o)
    else $error("reset write acknowledged");

  a_srst_defaults: assert property (@(posedge clk_i) disable iff (!resetn_i)
    srst |=> st.fast_trim == `OTC_FAST_TRIM_RST && st.mode == 16'h0000 && st.level == '0)
    else $error("soft reset left state");

  a_ident_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reg_rd_i && !srst && reg_addr_i == `OTC_OFF_IDENT |=> reg_rdata_o == {VERSION, PART_ID} && reg_ack_o)
    else $error("identity word wrong");

  a_flush_empty: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reg_wr_i && !srst && reg_addr_i == `OTC_OFF_FSTAT && reg_wdata_i[`OTC_BIT_FLUSH] |=> st.level == '0)
    else $error("flush did not empty FIFO");

  a_pop_level: assert property (@(posedge clk_i) disable iff (!resetn_i)
    pop && !push && !srst |=> st.level == $past(st.level) - 1'b1)
    else $error("read did not pop");

  a_fast_enable: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !sampling && !(st.clk_ctl[`OTC_BIT_FAST_EN_A] && st.clk_ctl[`OTC_BIT_FAST_EN_B]) |=> !fast_tick)
    else $error("fast oscillator ran while disabled");

  a_cal_stop: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !st.cal_ctl[`OTC_BIT_CAL_GO]
    && !(reg_wr_i && reg_addr_i == `OTC_OFF_CALCTL && reg_wdata_i[`OTC_BIT_CAL_GO])
    |=> st.cal_st == otc_pkg::OTC_CAL_IDLE)
    else $error("measurement kept running");

  a_rate_fifty: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st.frate[7:0] == 8'h00 && st.rate == `OTC_RATE_50HZ |-> div == `OTC_DIV_50HZ)
    else $error("rate code eight not fifty hertz");

  sequence s_cal_wr;
    reg_wr_i && !srst && reg_addr_i == `OTC_OFF_CALCTL && reg_wdata_i[`OTC_BIT_CAL_GO];
  endsequence
  a_cal_start: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_cal_wr |=> st.cal_st == otc_pkg::OTC_CAL_ARM)
    else $error("measurement not started");

  a_cal_sat: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st.cal_st == otc_pkg::OTC_CAL_RUN && st.cal_cnt == `OTC_CAL_MAX && !srst |=> st.cal_cnt == `OTC_CAL_MAX)
    else $error("count wrapped");
endmodule : otc_core
`default_nettype wire

// ### tb/otc_host.sv
// Host model: a single-access register master for the trim core.
// Assumes strobes are taken on a rising clock and acknowledged one cycle later.
`timescale 1ns/1ps
`default_nettype none
module otc_host (
  // Clock
  input  wire logic        clk_i,
  // Register port
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic [7:0]       reg_addr_o,
  output logic [15:0]      reg_wdata_o,
  input  wire logic [15:0] reg_rdata_i,
  input  wire logic        reg_ack_i
);
  initial
  begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 16'h0000;
  end

  // One access; read data is taken with the acknowledge
  task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] data,
                        output logic [15:0] rdata, output logic acked);
    int n;
    begin
      acked = 1'b0;
      rdata = 16'h0000;
      @(negedge clk_i);
      reg_wr_o    <= wr;
      reg_rd_o    <= !wr;
      reg_addr_o  <= addr;
      reg_wdata_o <= data;
      for (n = 0; n < 3; n++)
      begin
        @(negedge clk_i);
        if (n == 0)
        begin
          reg_wr_o    <= 1'b0;
          reg_rd_o    <= 1'b0;
          reg_addr_o  <= ~addr;
          reg_wdata_o <= ~data;
        end
        if (reg_ack_i === 1'b1 && !acked)
        begin
          acked = 1'b1;
          rdata = reg_rdata_i;
        end
      end
    end
  endtask : access
endmodule : otc_host
`default_nettype wire

// ### tb/oscillator_trim_calibration_test.sv
// Self-checking bench of the trim core.
// Assumes otc_host drives the register port and the bench drives sample data.
`timescale 1ns/1ps
`default_nettype none
`include "otc_map.svh"
module oscillator_trim_calibration_test;
  localparam logic [11:0] PART = 12'h3C7; // Arbitrary value
  localparam logic [3:0]  VER  = 4'h2;    // Arbitrary value
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        wr, rd, ack, sample, ftick, frun, acked;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, sdata, v, c1, d1;
  logic [15:0] ctl [4] = '{16'h0808, 16'h0008, 16'h0F4F, 16'h0040};
  logic        run [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  int          mismatches = 0;
  int          num_checks = 0;
  int          n;

  always #2.5 clk = ~clk;

  otc_core #(.PART_ID(PART), .VERSION(VER)) u_dut (
    .clk_i(clk), .resetn_i(resetn), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack), .sample_data_i(sdata),
    .sample_o(sample), .fast_tick_o(ftick), .fast_run_o(frun));

  otc_host u_host (
    .clk_i(clk), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_ack_i(ack));

  function automatic logic [15:0] ident_exp();
    return {VER, PART};
  endfunction : ident_exp

  function automatic logic [6:0] bytes_exp(input int words);
    return 7'(words * 2);
  endfunction : bytes_exp

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic regw(input logic [7:0] a, input logic [15:0] d);
    u_host.access(1'b1, a, d, v, acked);
  endtask : regw

  task automatic regr(input logic [7:0] a);
    u_host.access(1'b0, a, 16'h0000, v, acked);
  endtask : regr

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic give_up();
    mismatches++;
    $display("unexpected at %0t: wait ran out", $time);
    tally_and_finish();
  endtask : give_up

  task automatic take_sample(output logic [15:0] d);
    for (n = 0; n < 40000 && sample !== 1'b1; n++)
      @(negedge clk);
    if (sample !== 1'b1)
      give_up();
    d = sdata;
    @(negedge clk);
    sdata = 16'($urandom);
  endtask : take_sample

  initial
  begin
    void'($urandom(32'h531863B5));
    sdata = 16'($urandom);
    repeat (20) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    regr(`OTC_OFF_IDENT);
    chk(v, ident_exp());
    regw(`OTC_OFF_IDENT, 16'hFFFF);
    regr(`OTC_OFF_IDENT);
    chk(v, ident_exp());
    regr(8'h77);
    chk({15'h0000, acked}, 16'h0001);
    chk(v, 16'h0000);
    regr(`OTC_OFF_CALRES);
    chk(v, 16'h0000);
    $display("test identity done");
    c1 = 16'($urandom);
    regw(`OTC_OFF_FAST, c1);
    regr(`OTC_OFF_FAST);
    chk({8'h00, v[7:0]}, {8'h00, c1[7:0]});
    regw(`OTC_OFF_SLOW, {10'h000, c1[13:8]});
    regr(`OTC_OFF_SLOW);
    chk({10'h000, v[5:0]}, {10'h000, c1[13:8]});
    u_host.access(1'b1, `OTC_OFF_SRST, 16'h0001, v, acked);
    chk({15'h0000, acked}, 16'h0000);
    regr(`OTC_OFF_FAST);
    chk({8'h00, v[7:0]}, {8'h00, `OTC_FAST_TRIM_RST});
    regr(`OTC_OFF_CLKCTL);
    chk(v, `OTC_CLKCTL_RST);
    regr(`OTC_OFF_RATE);
    chk(v, {12'h000, `OTC_RATE_50HZ});
    $display("test soft reset done");
    for (int i = 0; i < 4; i++)
    begin
      regw(`OTC_OFF_CLKCTL, ctl[i]);
      chk({15'h0000, frun}, {15'h0000, run[i]});
      c1 = 16'h0000;
      repeat (16)
      begin
        @(negedge clk);
        c1 = c1 | {15'h0000, ftick};
      end
      chk(c1, {15'h0000, run[i]});
    end
    $display("test fast enable done");
    regw(`OTC_OFF_SLOW, 16'h00BF);
    regw(`OTC_OFF_CLKCTL, 16'h0808);
    regw(`OTC_OFF_CALCTL, 16'h0020);
    c1 = 16'h0000;
    for (int i = 0; i < 15 && c1 == 16'h0000; i++)
    begin
      repeat (1000) @(posedge clk);
      regr(`OTC_OFF_CALRES);
      c1 = v;
    end
    if (c1 === 16'h0000)
      give_up();
    chk({12'h000, c1[15:12]}, 16'h0000);
    regw(`OTC_OFF_FAST, 16'h00FF);
    regw(`OTC_OFF_CALCTL, 16'h0020);
    for (int i = 0; i < 15 && v === c1; i++)
    begin
      repeat (1000) @(posedge clk);
      regr(`OTC_OFF_CALRES);
    end
    if (v === c1)
      give_up();
    chk({15'h0000, v[11:0] > c1[11:0]}, 16'h0001);
    regw(`OTC_OFF_CALCTL, 16'h0000);
    $display("test calibration done");
    regw(`OTC_OFF_FRATE, 16'h0001);
    regw(`OTC_OFF_MODE, {12'h000, `OTC_MODE_SAMPLE});
    regw(`OTC_OFF_FSTAT, 16'h8000);
    take_sample(d1);
    take_sample(c1);
    regw(`OTC_OFF_CLKCTL, 16'h0F4F);
    regr(`OTC_OFF_FSTAT);
    chk({9'h000, v[14:8]}, {9'h000, bytes_exp(2)});
    regr(`OTC_OFF_FDATA);
    chk(v, d1);
    regr(`OTC_OFF_FSTAT);
    chk({9'h000, v[14:8]}, {9'h000, bytes_exp(1)});
    regw(`OTC_OFF_FSTAT, 16'h8000);
    regr(`OTC_OFF_FSTAT);
    chk({9'h000, v[14:8]}, 16'h0000);
    regr(`OTC_OFF_FDATA);
    chk(v, 16'h0000);
    regw(`OTC_OFF_CLKCTL, 16'h0040);
    $display("test sampling done");
    tally_and_finish();
  end
endmodule : oscillator_trim_calibration_test
`default_nettype wire
